// File: verilog/port_g_consts.svh
// register offsets, field positions and reset values for the port g mux
`ifndef PORT_G_CONSTS_SVH
`define PORT_G_CONSTS_SVH

`define PG_ADDR_W          4
`define PG_OFS_DIRECTION   4'h0
`define PG_OFS_OUT_LATCH   4'h1
`define PG_OFS_PIN_STATE   4'h2
`define PG_OFS_CS_ENABLE   4'h3
`define PG_PINS            7
`define PG_DIR_RESET       7'h00
`define PG_LATCH_RESET     7'h00
`define PG_CS_RESET        8'h00
`define PG_UNDEF_READ      8'h00
`define PG_PIN_BUS_REQUEST_IN        6
`define PG_PIN_BACK        5
`define PG_PIN_BUS_REQUEST_OUT       4

`endif

// File: verilog/port_g_pkg.sv
// types for the port g pin function multiplexer
package port_g_pkg;
	// memory type of the area behind a chip select pin
	typedef enum logic [1:0] {
		MEM_NORMAL = 2'h0,
		MEM_DRAM   = 2'h1,
		MEM_SDRAM  = 2'h2
	} mem_type_e;

	// operating mode 1 to 7
	typedef logic [2:0] op_mode_t;
endpackage : port_g_pkg

// File: verilog/port_g_pin_function_mux.sv
// pin function selection and read-back for the seven-bit port g
`timescale 1ns/1ps
`include "port_g_consts.svh"

module port_g_pin_function_mux
	import port_g_pkg::*;
(
	input  wire logic                  clk_sys,
	input  wire logic                  rst,
	input  wire logic [`PG_ADDR_W-1:0] regAddr,
	input  wire logic [7:0]            regWrData,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [7:0]            regRdData,
	input  wire op_mode_t              opMode,
	input  wire logic                  externalExpansionEnable,
	input  wire logic                  busReleaseEnable,
	input  wire logic                  busRequestOutEnable,
	input  wire mem_type_e             memTypeArea3,
	input  wire mem_type_e             memTypeArea2,
	input  wire logic                  busAckOut,
	input  wire logic                  busRequestOutSig,
	input  wire logic [3:0]            chipSelectLine,
	input  wire logic                  areaRowStrobe3,
	input  wire logic                  areaRowStrobe2,
	input  wire logic                  sdramRowStrobe,
	input  wire logic                  sdramColStrobe,
	output logic                       busRequestIn,
	output logic      [7:0]            chipSelectEnable,
	input  wire logic [6:0]            pinIn,
	output logic      [6:0]            pinOut,
	output logic      [6:0]            pinOe
);

	logic [6:0] dirBits_q;
	logic [6:0] outLatch_q;
	logic [7:0] csEnable_q;
	logic [7:0] rdData_q;
	logic       extBus;
	logic       releaseOn;
	logic [6:0] pinState;
	logic       wrDir;
	logic       wrLatch;
	logic       wrCs;

	assign wrDir   = regWrite && (regAddr == `PG_OFS_DIRECTION);
	assign wrLatch = regWrite && (regAddr == `PG_OFS_OUT_LATCH);
	assign wrCs    = regWrite && (regAddr == `PG_OFS_CS_ENABLE);

	// mode 3 and 7 need expansion enabled for the external bus
	// mode inputs
	assign extBus = (opMode == 3'h3 || opMode == 3'h7) ?
		externalExpansionEnable :
		(opMode != 3'h0);
	assign releaseOn = extBus && busReleaseEnable;

	// direction bits, write-only
	// direction write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dirBits_q <= `PG_DIR_RESET;
		end else if (wrDir) begin
			dirBits_q <= regWrData[6:0];
		end
	end

	// output latch, bit 7 is not stored at all
	// latch store
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			outLatch_q <= `PG_LATCH_RESET;
		end else if (wrLatch) begin
			outLatch_q <= regWrData[6:0];
		end
	end

	// chip select enables for all eight lines
	// enable register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			csEnable_q <= `PG_CS_RESET;
		end else if (wrCs) begin
			csEnable_q <= regWrData;
		end
	end
	assign chipSelectEnable = csEnable_q;

	// pin state: latch on output bits, pin level on input bits
	// latch readback
	assign pinState = (dirBits_q & outLatch_q) | (~dirBits_q & pinIn);

	// read data one cycle after the strobe; writes to pin state are ignored
	// read-only state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdData_q <= 8'h00;
		end else if (regRead) begin
			case (regAddr)
				`PG_OFS_DIRECTION: rdData_q <= `PG_UNDEF_READ;
				`PG_OFS_OUT_LATCH: rdData_q <= {1'b0, outLatch_q};
				`PG_OFS_PIN_STATE: rdData_q <= {1'b0, pinState};
				`PG_OFS_CS_ENABLE: rdData_q <= csEnable_q;
				default:           rdData_q <= 8'h00;
			endcase
		end else begin
			rdData_q <= 8'h00;
		end
	end
	assign regRdData = rdData_q;

	// pin 6: request input only listened to while released
	// request input
	assign busRequestIn = releaseOn ? pinIn[`PG_PIN_BUS_REQUEST_IN] : 1'b1;

	// per-pin output mux, combinational from flop state and bus signals
	always_comb begin
		pinOut = outLatch_q;
		pinOe  = dirBits_q;
		if (releaseOn) begin
			pinOe[6] = 1'b0;
		end
		if (releaseOn) begin
			pinOut[5] = busAckOut;
			pinOe[5]  = 1'b1;
		end
		if (releaseOn && busRequestOutEnable) begin
			pinOut[4] = busRequestOutSig;
			pinOe[4]  = 1'b1;
		end
		if (extBus && csEnable_q[3]) begin
			case (memTypeArea3)
				MEM_DRAM: begin
					pinOut[3] = areaRowStrobe3;
					pinOe[3]  = 1'b1;
				end
				MEM_SDRAM: begin
					pinOut[3] = sdramColStrobe;
					pinOe[3]  = 1'b1;
				end
				default: begin
					pinOut[3] = chipSelectLine[3];
					pinOe[3]  = dirBits_q[3];
				end
			endcase
		end
		if (extBus && csEnable_q[2]) begin
			case (memTypeArea2)
				MEM_DRAM: begin
					pinOut[2] = areaRowStrobe2;
					pinOe[2]  = 1'b1;
				end
				MEM_SDRAM: begin
					pinOut[2] = sdramRowStrobe;
					pinOe[2]  = 1'b1;
				end
				default: begin
					pinOut[2] = chipSelectLine[2];
					pinOe[2]  = dirBits_q[2];
				end
			endcase
		end
		for (int i = 0; i < 2; i++) begin
			if (extBus && csEnable_q[i]) begin
				pinOut[i] = chipSelectLine[i];
			end
		end
	end

	// register path: readback, write effects and reset value
	// latch readback
	AST_RB_LATCH: assert property (
		@(posedge clk_sys) disable iff (rst)
		regRead && regAddr == `PG_OFS_PIN_STATE |=>
		regRdData[6:0] == (($past(dirBits_q) & $past(outLatch_q)) |
		(~$past(dirBits_q) & $past(pinIn))))
		else $error("pin state readback wrong");
	AST_RB_PIN: assert property (
		@(posedge clk_sys) disable iff (rst)
		regRead && regAddr == `PG_OFS_PIN_STATE && dirBits_q == 7'h00
		|=> regRdData[6:0] == $past(pinIn))
		else $error("input pins not read back");
	AST_RO_STATE: assert property (
		@(posedge clk_sys) disable iff (rst)
		regWrite && regAddr == `PG_OFS_PIN_STATE |=>
		$stable(dirBits_q) && $stable(outLatch_q) && $stable(csEnable_q))
		else $error("pin state write had effect");
	AST_CS_WRITE: assert property (
		@(posedge clk_sys) disable iff (rst)
		wrCs |=> csEnable_q == $past(regWrData))
		else $error("chip select enable not written");
	// enable reset; watched through reset on purpose
	AST_CS_RESET: assert property (
		@(posedge clk_sys)
		rst |=> csEnable_q == `PG_CS_RESET)
		else $error("chip select enable not cleared by reset");
	AST_DIR_WRITE: assert property (
		@(posedge clk_sys) disable iff (rst)
		wrDir |=> dirBits_q == $past(regWrData[6:0]))
		else $error("direction bits not written");
	AST_LATCH_WRITE: assert property (
		@(posedge clk_sys) disable iff (rst)
		wrLatch |=> outLatch_q == $past(regWrData[6:0]))
		else $error("output latch not written");
	AST_LATCH_B7: assert property (
		@(posedge clk_sys) disable iff (rst)
		regRead && regAddr == `PG_OFS_OUT_LATCH |=> !regRdData[7])
		else $error("latch bit 7 not zero");

	// pin function checks, at least one per pin
	// pin6 released
	AST_PIN6_IN: assert property (
		@(posedge clk_sys) disable iff (rst)
		releaseOn |-> !pinOe[6])
		else $error("pin 6 driven while released");
	AST_REQ_IN: assert property (
		@(posedge clk_sys) disable iff (rst)
		releaseOn |-> busRequestIn == pinIn[`PG_PIN_BUS_REQUEST_IN])
		else $error("bus request not taken from pin 6");
	AST_PIN6_GP: assert property (
		@(posedge clk_sys) disable iff (rst)
		!releaseOn |-> pinOe[6] == dirBits_q[6]
		&& pinOut[6] == outLatch_q[6])
		else $error("pin 6 not general port");
	AST_PIN5_ACK: assert property (
		@(posedge clk_sys) disable iff (rst)
		releaseOn |-> pinOe[5] && pinOut[5] == busAckOut)
		else $error("acknowledge not driven");
	AST_PIN5_GP: assert property (
		@(posedge clk_sys) disable iff (rst)
		!releaseOn |-> pinOe[5] == dirBits_q[5]
		&& pinOut[5] == outLatch_q[5])
		else $error("pin 5 not general port");
	AST_PIN4_REQ: assert property (
		@(posedge clk_sys) disable iff (rst)
		releaseOn && busRequestOutEnable |->
		pinOe[4] && pinOut[4] == busRequestOutSig)
		else $error("request out not driven");
	AST_PIN4_GP: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(releaseOn && busRequestOutEnable) |-> pinOe[4] == dirBits_q[4]
		&& pinOut[4] == outLatch_q[4])
		else $error("pin 4 not general port");
	AST_PIN3_GP: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(extBus && csEnable_q[3]) |-> pinOe[3] == dirBits_q[3]
		&& pinOut[3] == outLatch_q[3])
		else $error("pin 3 not general port");
	AST_PIN2_GP: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(extBus && csEnable_q[2]) |-> pinOe[2] == dirBits_q[2]
		&& pinOut[2] == outLatch_q[2])
		else $error("pin 2 not general port");
	AST_PIN3_CAS: assert property (
		@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[3] && memTypeArea3 == MEM_SDRAM
		|-> pinOe[3] && pinOut[3] == sdramColStrobe)
		else $error("column strobe missing");
	AST_PIN3_DRAM: assert property (
		@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[3] && memTypeArea3 == MEM_DRAM
		|-> pinOe[3] && pinOut[3] == areaRowStrobe3)
		else $error("area 3 row strobe missing");
	AST_PIN2_RAS: assert property (
		@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[2] && memTypeArea2 == MEM_SDRAM
		|-> pinOe[2] && pinOut[2] == sdramRowStrobe)
		else $error("row strobe missing");
	AST_PIN2_CS: assert property (
		@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[2] && memTypeArea2 == MEM_NORMAL
		|-> pinOe[2] == dirBits_q[2] && pinOut[2] == chipSelectLine[2])
		else $error("pin 2 chip select wrong");
	AST_PIN0_CS: assert property (
		@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[0] |-> pinOe[0] == dirBits_q[0]
		&& pinOut[0] == chipSelectLine[0])
		else $error("pin 0 chip select wrong");
	AST_PIN1_GP: assert property (
		@(posedge clk_sys) disable iff (rst)
		!(extBus && csEnable_q[1]) |-> pinOe[1] == dirBits_q[1]
		&& pinOut[1] == outLatch_q[1])
		else $error("pin 1 not general port");
	AST_DIR_OE: assert property (
		@(posedge clk_sys) disable iff (rst)
		!extBus |-> pinOe == dirBits_q && pinOut == outLatch_q)
		else $error("port not under direction control");

	// main scenarios reached by the tests
	COV_RELEASE: cover property (@(posedge clk_sys) disable iff (rst)
		releaseOn && busRequestOutEnable);
	COV_SDRAM: cover property (@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[2] && memTypeArea2 == MEM_SDRAM);
	COV_DRAM: cover property (@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[3] && memTypeArea3 == MEM_DRAM);
	COV_CS_PIN0: cover property (@(posedge clk_sys) disable iff (rst)
		extBus && csEnable_q[0] && dirBits_q[0]);
	COV_READBACK: cover property (@(posedge clk_sys) disable iff (rst)
		regRead && regAddr == `PG_OFS_PIN_STATE && dirBits_q != 7'h00);

endmodule : port_g_pin_function_mux

// File: tb/pin_world.sv
// outside drivers and loads seen on the seven port pins
`timescale 1ns/1ps
module pin_world (
	input  wire logic [6:0] pinOut,
	input  wire logic [6:0] pinOe,
	input  wire logic [6:0] extLevel,
	output logic      [6:0] pinIn
);
	// a driven pin reads its own level; the bench sets every undriven one
	always_comb pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : pin_world

// File: tb/port_g_pin_function_mux_test.sv
// self-checking bench for the port g pin function mux
`timescale 1ns/1ps
`include "port_g_consts.svh"
module port_g_pin_function_mux_test
	import port_g_pkg::*;
;
	logic       clk_sys = 0, rst = 1, regWrite = 0, regRead = 0;
	logic [3:0] regAddr = 4'h0, chipSelectLine = 4'h0;
	logic [7:0] regWrData = 8'h00, regRdData, chipSelectEnable, rdv;
	op_mode_t   opMode = 3'h0;
	logic       externalExpansionEnable = 0, busReleaseEnable = 0;
	logic       busRequestOutEnable = 0, busAckOut = 1, busRequestOutSig = 1;
	mem_type_e  memTypeArea3 = MEM_NORMAL, memTypeArea2 = MEM_NORMAL;
	logic       areaRowStrobe3 = 0, areaRowStrobe2 = 0;
	logic       sdramRowStrobe = 0, sdramColStrobe = 0, busRequestIn, xb, v;
	logic [6:0] pinIn, pinOut, pinOe, extLevel = 7'h55;
	int         num_errors = 0, comparisons = 0;

	port_g_pin_function_mux port_g_pin_function_mux_inst (.clk_sys, .rst,
		.regAddr, .regWrData, .regWrite, .regRead, .regRdData, .opMode,
		.externalExpansionEnable, .busReleaseEnable, .busRequestOutEnable,
		.memTypeArea3, .memTypeArea2, .busAckOut, .busRequestOutSig,
		.chipSelectLine, .areaRowStrobe3, .areaRowStrobe2, .sdramRowStrobe,
		.sdramColStrobe, .busRequestIn, .chipSelectEnable, .pinIn, .pinOut,
		.pinOe);
	pin_world pin_world_inst (.pinOut, .pinOe, .extLevel, .pinIn);

	// 40 MHz system clock
	always #12.5 clk_sys = ~clk_sys;

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk

	// one-cycle write strobe, released at the taking edge
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk_sys);
		regWrite <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk_sys);
		regRead <= 1'b0;
		@(negedge clk_sys);
		rdv = regRdData;
	endtask : rd

	task results;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// cut a hang short well past the expected run length
	initial begin
		repeat (5000) @(posedge clk_sys);
		num_errors++;
		results();
	end

	// test sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd(`PG_OFS_CS_ENABLE);
		chk(rdv, 8'h00);
		rd(`PG_OFS_PIN_STATE);
		chk({1'b0, rdv[6:0]}, 8'h55);
		$display("test reset done");
		// bit 7 of the latch is not writable
		wr(`PG_OFS_DIRECTION, 8'h0D);
		wr(`PG_OFS_OUT_LATCH, 8'h8A);
		rd(`PG_OFS_OUT_LATCH);
		chk(rdv, 8'h0A);
		rd(`PG_OFS_PIN_STATE);
		chk({1'b0, rdv[6:0]}, 8'h58);
		chk({1'b0, pinOe}, 8'h0D);
		chk({1'b0, pinOut & pinOe}, 8'h08);
		wr(`PG_OFS_PIN_STATE, 8'hFF);
		rd(`PG_OFS_PIN_STATE);
		chk({1'b0, rdv[6:0]}, 8'h58);
		chk({1'b0, pinOe}, 8'h0D);
		rd(`PG_OFS_DIRECTION);
		chk(rdv, 8'h00);
		rd(4'hF);
		chk(rdv, 8'h00);
		$display("test readback done");
		// every mode, with and without expansion, bus levels toggled
		@(posedge clk_sys);
		extLevel <= 7'h15;
		busReleaseEnable <= 1'b1;
		wr(`PG_OFS_DIRECTION, 8'h00);
		for (int m = 0; m < 16; m++) begin
			@(posedge clk_sys);
			opMode <= m[2:0];
			externalExpansionEnable <= m[3];
			busRequestOutEnable <= m[0];
			busAckOut <= m[1];
			busRequestOutSig <= ~m[1];
			extLevel <= {m[2], 6'h15};
			@(negedge clk_sys);
			xb = m[2:0] inside {1, 2, 4, 5, 6} ||
				(m[2:0] inside {3, 7} && m[3]);
			v = xb & m[0] & ~m[1];
			chk({7'h0, busRequestIn}, {7'h0, !xb || m[2]});
			chk({6'h0, pinOe[6:5]}, {6'h0, 1'b0, xb});
			chk({7'h0, pinOe[4]}, {7'h0, xb & m[0]});
			chk({7'h0, pinOut[5] & pinOe[5]}, {7'h0, xb & m[1]});
			chk({7'h0, pinOut[4] & pinOe[4]}, {7'h0, v});
		end
		$display("test bus release done");
		wr(`PG_OFS_DIRECTION, 8'h0D);
		wr(`PG_OFS_CS_ENABLE, 8'hFF);
		@(negedge clk_sys);
		chk(chipSelectEnable, 8'hFF);
		// each memory type against four strobe patterns
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_sys);
			opMode <= 3'h1;
			memTypeArea3 <= mem_type_e'(i / 4);
			memTypeArea2 <= mem_type_e'(i / 4);
			areaRowStrobe3 <= i[0];
			areaRowStrobe2 <= ~i[0];
			sdramRowStrobe <= ~i[1];
			sdramColStrobe <= i[1];
			chipSelectLine <= {~(i[0] ^ i[1]), i[0] ^ i[1], 1'b0, i[0]};
			@(negedge clk_sys);
			v = (i / 4 == 0) ? ~(i[0] ^ i[1]) : (i / 4 == 1) ? i[0] : i[1];
			chk({4'h0, pinOe[3:0]}, 8'h0D);
			chk({4'h0, pinOut[3:0] & 4'hD}, {4'h0, v, ~v, 1'b0, i[0]});
		end
		@(posedge clk_sys);
		opMode <= 3'h3;
		externalExpansionEnable <= 1'b0;
		@(negedge clk_sys);
		chk({1'b0, pinOut & pinOe}, 8'h08);
		$display("test chip select done");
		results();
	end
endmodule : port_g_pin_function_mux_test
